//--- hw/wwdt_top.sv
// wwdt_top.sv: window watchdog with classic wishbone register slave.
// assumes lsclk_tick_i is a one-cycle pulse per low-speed clock period,
// synchronous to clk_i, and cfg bytes are the two flash copies.
//
// Register access over Wishbone was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

`include "wwdt_params.svh"

module wwdt_top (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // configuration copies in flash
    input  wire logic [7:0]  cfg_primary_i,
    input  wire logic [7:0]  cfg_alternate_i,
    input  wire logic        boot_swap_i,
    // low-speed clock and standby
    input  wire logic        lsclk_tick_i,
    input  wire logic        standby_i,
    // watchdog outputs
    output logic             interval_irq_o,
    output logic             wdt_reset_o,
    output logic             lsosc_run_o
);
    import wwdt_pkg::*;

    // ========================================================================
    // decode helpers
    function automatic logic [4:0] ovf_exp(input logic [2:0] sel);
        unique case (sel)
            3'b000: ovf_exp = 5'd6;
            3'b001: ovf_exp = 5'd7;
            3'b010: ovf_exp = 5'd8;
            3'b011: ovf_exp = 5'd9;
            3'b100: ovf_exp = 5'd11;
            3'b101: ovf_exp = 5'd13;
            3'b110: ovf_exp = 5'd14;
            3'b111: ovf_exp = 5'd16;
        endcase
    endfunction : ovf_exp

    // first count of the open window, in low-speed clock ticks of the counter
    function automatic logic [16:0] win_start(input logic [1:0] sel,
                                              input logic [16:0] len);
        unique case (wwdt_win_t'(sel))
            WWDT_WIN_50:  win_start = len >> 1;
            WWDT_WIN_75:  win_start = len >> 2;
            WWDT_WIN_100: win_start = 17'h0_0000;
            default:      win_start = 17'h0_0000;
        endcase
    endfunction : win_start

    // ========================================================================
    // state
    wwdt_state_t st_reg;
    wwdt_state_t st_next;

    logic              irq_en;
    logic [1:0]        win_sel;
    logic              cnt_en;
    logic [2:0]        ovf_sel;
    logic              stby_run;
    logic [16:0]       ovf_len;
    logic [16:0]       cnt_ext;
    logic [16:0]       open_at;
    logic              stopped;
    logic              req;
    logic              wr;
    logic              bad_key;
    logic              closed;
    logic              fault;

    assign irq_en   = st_reg.cfg[`WWDT_CFG_IRQ_EN_BIT];
    assign win_sel  = st_reg.cfg[`WWDT_CFG_WIN_HI_BIT:`WWDT_CFG_WIN_LO_BIT];
    assign cnt_en   = st_reg.cfg[`WWDT_CFG_ENABLE_BIT] & st_reg.cfg_loaded;
    assign ovf_sel  = st_reg.cfg[`WWDT_CFG_OVF_HI_BIT:`WWDT_CFG_OVF_LO_BIT];
    assign stby_run = st_reg.cfg[`WWDT_CFG_STBY_RUN_BIT];
    assign ovf_len  = 17'h0_0001 << ovf_exp(ovf_sel);
    assign cnt_ext  = {1'b0, st_reg.cnt};
    assign open_at  = stby_run ? win_start(win_sel, ovf_len) : 17'h0_0000;
    assign stopped  = standby_i & ~stby_run & ~st_reg.clock_keep;
    assign req      = wb_cyc_i & wb_stb_i & ~st_reg.ack;
    assign wr       = req & wb_we_i;
    assign bad_key  = (wb_dat_i[7:0] != `WWDT_RESTART_KEY)
                      | (wb_sel_i != `WWDT_KEY_LANE);
    assign closed   = ~st_reg.first_restart & (cnt_ext < open_at);

    // ========================================================================
    // next state
    always_comb begin
        st_next           = st_reg;
        st_next.ack       = req;
        st_next.irq       = 1'b0;
        st_next.wdt_reset = 1'b0;
        fault             = 1'b0;

        // configuration capture at release, flash copy chosen by boot swap
        if (!st_reg.cfg_loaded) begin
            st_next.cfg        = boot_swap_i ? cfg_alternate_i : cfg_primary_i;
            st_next.cfg_loaded = 1'b1;
        end

        // counting; flash programming has no input here so it never stalls
        if (cnt_en) begin
            if (stopped) begin
                st_next.cnt = `WWDT_CNT_RESET;
            end else if (lsclk_tick_i) begin
                if (cnt_ext == ovf_len - 17'h0_0001) begin
                    fault = 1'b1;
                end else begin
                    st_next.cnt = st_reg.cnt + `WWDT_CNT_W'(1);
                    if (irq_en && (cnt_ext + 17'h0_0001
                                   == ovf_len - (ovf_len >> 2))) begin
                        st_next.irq = 1'b1;
                    end
                end
            end
        end

        // register reads
        st_next.dat = `WWDT_DATA_RESET;
        if (req && !wb_we_i) begin
            unique case (wb_adr_i)
                `WWDT_OFS_RESET_CAUSE:
                    st_next.dat[`WWDT_RESET_FLAG_BIT] = st_reg.reset_flag;
                `WWDT_OFS_CONTROL:
                    st_next.dat[`WWDT_CLOCK_KEEP_BIT] = st_reg.clock_keep;
                `WWDT_OFS_COUNTER:
                    st_next.dat[`WWDT_CNT_W-1:0] = st_reg.cnt;
                `WWDT_OFS_CONFIG_BYTE:
                    st_next.dat[7:0] = st_reg.cfg;
                default:
                    st_next.dat = `WWDT_DATA_RESET;
            endcase
        end

        // register writes; the config byte has no write path
        if (wr) begin
            unique case (wb_adr_i)
                `WWDT_OFS_RESTART_KEY: begin
                    if (cnt_en) begin
                        if (bad_key || closed) begin
                            fault = 1'b1;
                        end else begin
                            st_next.cnt           = `WWDT_CNT_RESET;
                            st_next.first_restart = 1'b0;
                        end
                    end
                end
                `WWDT_OFS_RESET_CAUSE:
                    st_next.reset_flag = 1'b0;
                `WWDT_OFS_CONTROL:
                    st_next.clock_keep = wb_dat_i[`WWDT_CLOCK_KEEP_BIT];
                default: begin
                end
            endcase
        end

        // watchdog reset: set wins over a clear in the same cycle
        if (fault) begin
            st_next.cnt           = `WWDT_CNT_RESET;
            st_next.reset_flag    = 1'b1;
            st_next.first_restart = 1'b1;
            st_next.wdt_reset     = 1'b1;
            st_next.irq           = 1'b0;
        end

        st_next.osc_run = (st_reg.cfg[`WWDT_CFG_ENABLE_BIT] & st_reg.cfg_loaded
                           & ~stopped) | st_next.clock_keep;
    end

    // ========================================================================
    // state register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg.cfg           <= `WWDT_CFG_RESET;
            st_reg.cfg_loaded    <= 1'b0;
            st_reg.first_restart <= 1'b1;
            st_reg.cnt           <= `WWDT_CNT_RESET;
            st_reg.clock_keep    <= 1'b0;
            st_reg.reset_flag    <= 1'b0;
            st_reg.ack           <= 1'b0;
            st_reg.dat           <= `WWDT_DATA_RESET;
            st_reg.irq           <= 1'b0;
            st_reg.wdt_reset     <= 1'b0;
            st_reg.osc_run       <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end

    // ========================================================================
    // outputs
    assign wb_dat_o       = st_reg.dat;
    assign wb_ack_o       = st_reg.ack;
    assign interval_irq_o = st_reg.irq;
    assign wdt_reset_o    = st_reg.wdt_reset;
    assign lsosc_run_o    = st_reg.osc_run;

endmodule : wwdt_top

`default_nettype wire

//--- hw/wwdt_params.svh
// wwdt_params.svh: offsets, field positions, reset values and counts of the
// window watchdog; assumes inclusion by bare name from hw/.
`ifndef WWDT_PARAMS_SVH
`define WWDT_PARAMS_SVH

// ============================================================================
// register byte addresses
`define WWDT_OFS_RESTART_KEY   8'h00
`define WWDT_OFS_RESET_CAUSE   8'h04
`define WWDT_OFS_CONTROL       8'h08
`define WWDT_OFS_COUNTER       8'h0C
`define WWDT_OFS_CONFIG_BYTE   8'hC0

// ============================================================================
// configuration byte fields
`define WWDT_CFG_IRQ_EN_BIT    7
`define WWDT_CFG_WIN_HI_BIT    6
`define WWDT_CFG_WIN_LO_BIT    5
`define WWDT_CFG_ENABLE_BIT    4
`define WWDT_CFG_OVF_HI_BIT    3
`define WWDT_CFG_OVF_LO_BIT    1
`define WWDT_CFG_STBY_RUN_BIT  0

// ============================================================================
// other fields and values
`define WWDT_RESET_FLAG_BIT    4
`define WWDT_CLOCK_KEEP_BIT    0
`define WWDT_RESTART_KEY       8'hAC
`define WWDT_KEY_LANE          4'h1
`define WWDT_CNT_W             16
`define WWDT_CNT_RESET         16'h0000
`define WWDT_CFG_RESET         8'h00
`define WWDT_DATA_RESET        32'h0000_0000

`endif

//--- hw/wwdt_pkg.sv
// wwdt_pkg.sv: types of the window watchdog.
// assumes wwdt_params.svh is on the include path.
`include "wwdt_params.svh"

package wwdt_pkg;

    // ========================================================================
    // window open period codes
    typedef enum logic [1:0] {
        WWDT_WIN_BAD  = 2'b00,
        WWDT_WIN_50   = 2'b01,
        WWDT_WIN_75   = 2'b10,
        WWDT_WIN_100  = 2'b11
    } wwdt_win_t;

    // ========================================================================
    // whole state of the watchdog
    typedef struct packed {
        logic [7:0]              cfg;
        logic                    cfg_loaded;
        logic                    first_restart;
        logic [`WWDT_CNT_W-1:0]  cnt;
        logic                    clock_keep;
        logic                    reset_flag;
        logic                    ack;
        logic [31:0]             dat;
        logic                    irq;
        logic                    wdt_reset;
        logic                    osc_run;
    } wwdt_state_t;

endpackage : wwdt_pkg

//--- verification/wwdt_props.sv
// wwdt_props.sv: port-level assertions for the window watchdog.
// assumes it is bound onto wwdt_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module wwdt_props (
    // clock, reset and bus
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // configuration and watchdog
    input wire logic [7:0]  cfg_primary_i,
    input wire logic [7:0]  cfg_alternate_i,
    input wire logic        boot_swap_i,
    input wire logic        lsclk_tick_i,
    input wire logic        interval_irq_o,
    input wire logic        wdt_reset_o
);
    wire logic en_cfg = boot_swap_i ? cfg_alternate_i[4] : cfg_primary_i[4];
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ========================================================================
    // properties
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    property p_ack_req; $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i); endproperty
    property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0000_0000; endproperty
    property p_rst_pulse; wdt_reset_o |=> !wdt_reset_o; endproperty
    property p_irq_pulse; interval_irq_o |=> !interval_irq_o; endproperty
    property p_irq_tick; interval_irq_o |-> $past(lsclk_tick_i); endproperty
    property p_ovf_tick;
        wdt_reset_o && !$past(wb_cyc_i && wb_stb_i) |-> $past(lsclk_tick_i);
    endproperty
    property p_key_bad;
        wb_ack_o && $past(en_cfg && wb_we_i && wb_adr_i == 8'h00
            && (wb_dat_i[7:0] != 8'hAC || wb_sel_i != 4'h1)) |-> wdt_reset_o;
    endproperty
    // ========================================================================
    // assertions and covers
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");
    a_ack_req: assert property (p_ack_req) else $error("ack without request");
    a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
    a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse too long");
    a_irq_pulse: assert property (p_irq_pulse) else $error("irq pulse too long");
    a_irq_tick: assert property (p_irq_tick) else $error("irq without tick");
    a_ovf_tick: assert property (p_ovf_tick) else $error("reset without cause");
    a_key_bad: assert property (p_key_bad) else $error("bad key not punished");
    c_irq: cover property (interval_irq_o);
    c_ovf: cover property (wdt_reset_o && $past(lsclk_tick_i));
    c_wr: cover property (wb_ack_o && $past(wb_we_i));
endmodule : wwdt_props
bind wwdt_top wwdt_props i_wwdt_props (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .cfg_primary_i(cfg_primary_i), .cfg_alternate_i(cfg_alternate_i),
    .boot_swap_i(boot_swap_i), .lsclk_tick_i(lsclk_tick_i),
    .interval_irq_o(interval_irq_o), .wdt_reset_o(wdt_reset_o));
`default_nettype wire

//--- verification/testbench.sv
// testbench.sv: register-level tests of the window watchdog.
// assumes wwdt_top, wwdt_params.svh and the bound checker are compiled.
`timescale 1ns/1ps
`default_nettype none
`include "wwdt_params.svh"
module testbench;
    logic        clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
    logic [7:0]  wb_adr_i = 8'h00, cfg_primary_i = 8'hB1, cfg_alternate_i = 8'hB0;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, rd;
    logic        wb_ack_o, boot_swap_i = 0, lsclk_tick_i = 0, standby_i = 0;
    logic        interval_irq_o, wdt_reset_o, lsosc_run_o;
    int          err_total = 0, compares = 0, n_rst = 0, n_irq = 0;
    always #5 clk_i = ~clk_i;
    wwdt_top i_wwdt_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .cfg_primary_i(cfg_primary_i), .cfg_alternate_i(cfg_alternate_i),
        .boot_swap_i(boot_swap_i), .lsclk_tick_i(lsclk_tick_i), .standby_i(standby_i),
        .interval_irq_o(interval_irq_o), .wdt_reset_o(wdt_reset_o),
        .lsosc_run_o(lsosc_run_o));
    always @(posedge clk_i) begin
        if (wdt_reset_o === 1'b1) n_rst++;
        if (interval_irq_o === 1'b1) n_irq++;
    end
    // ========================================================================
    // tasks
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1; wb_stb_i <= 1; wb_we_i <= w; wb_adr_i <= a; wb_dat_i <= d;
        wb_sel_i <= s;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 40);
        if (n >= 40) begin
            chk("ack", 1'b0, 1'b1);
            give_verdict();
        end else begin
            rd = wb_dat_o;
            wb_cyc_i <= 0; wb_stb_i <= 0; wb_we_i <= 0;
            repeat (2) @(posedge clk_i);
        end
    endtask : bus
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge clk_i) lsclk_tick_i <= 1;
            @(posedge clk_i) lsclk_tick_i <= 0;
        end
        repeat (3) @(posedge clk_i);
    endtask : ticks
    task automatic key(input logic [31:0] d, input logic [3:0] s);
        bus(1, `WWDT_OFS_RESTART_KEY, d, s);
    endtask : key
    task automatic do_reset();
        @(posedge clk_i) rst_i <= 1;
        repeat (16) @(posedge clk_i);
        rst_i <= 0;
        repeat (3) @(posedge clk_i);
    endtask : do_reset
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : give_verdict
    initial begin
        #400000;
        err_total++;
        give_verdict();
    end
    // ========================================================================
    // tests
    initial begin
        do_reset();
        bus(0, `WWDT_OFS_CONFIG_BYTE, 0, 4'hF); chk("cfg", rd, 32'h0000_00B1);
        ticks(10); bus(0, `WWDT_OFS_COUNTER, 0, 4'hF); chk("cnt", rd, 32'd10);
        key(`WWDT_RESTART_KEY, 4'h1); chk("first", n_rst, 0);
        bus(0, `WWDT_OFS_COUNTER, 0, 4'hF); chk("cnt0", rd, 32'd0);
        ticks(10); key(`WWDT_RESTART_KEY, 4'h1); chk("closed", n_rst, 1);
        bus(0, `WWDT_OFS_RESET_CAUSE, 0, 4'hF); chk("flag", rd, 32'h0000_0010);
        bus(0, `WWDT_OFS_COUNTER, 0, 4'hF); chk("cntr", rd, 32'd0);
        bus(1, `WWDT_OFS_RESET_CAUSE, 0, 4'h1); bus(0, `WWDT_OFS_RESET_CAUSE, 0, 4'hF);
        chk("flagclr", rd, 32'h0000_0000);
        key(`WWDT_RESTART_KEY, 4'h1); ticks(31); key(`WWDT_RESTART_KEY, 4'h1);
        chk("edge31", n_rst, 2);
        key(`WWDT_RESTART_KEY, 4'h1); ticks(32); key(`WWDT_RESTART_KEY, 4'h1);
        chk("edge32", n_rst, 2);
        ticks(48); chk("irq", n_irq, 1);
        ticks(15); chk("noovf", n_rst, 2);
        ticks(1); chk("ovf", n_rst, 3);
        key(32'h0000_0055, 4'h1); chk("badkey", n_rst, 4);
        key(`WWDT_RESTART_KEY, 4'h3); chk("badsel", n_rst, 5);
        standby_i <= 1; ticks(5); chk("osc", lsosc_run_o, 1'b1);
        bus(0, `WWDT_OFS_COUNTER, 0, 4'hF); chk("stbycnt", rd, 32'd5);
        standby_i <= 0; bus(0, 8'h40, 0, 4'hF); chk("unmapped", rd, 32'd0);
        $display("test window config done");
        boot_swap_i <= 1; do_reset();
        bus(0, `WWDT_OFS_CONFIG_BYTE, 0, 4'hF); chk("alt", rd, 32'h0000_00B0);
        key(`WWDT_RESTART_KEY, 4'h1); ticks(5); key(`WWDT_RESTART_KEY, 4'h1);
        chk("full", n_rst, 5);
        standby_i <= 1; ticks(5); chk("oscoff", lsosc_run_o, 1'b0);
        bus(0, `WWDT_OFS_COUNTER, 0, 4'hF); chk("held", rd, 32'd0);
        bus(1, `WWDT_OFS_CONTROL, 1, 4'h1); repeat (2) @(posedge clk_i);
        chk("keep", lsosc_run_o, 1'b1);
        standby_i <= 0; $display("test standby config done");
        boot_swap_i <= 0; cfg_primary_i <= 8'h33; do_reset();
        key(`WWDT_RESTART_KEY, 4'h1); ticks(127); chk("noirq", n_irq, 1);
        chk("len128", n_rst, 5);
        ticks(1); chk("ovf128", n_rst, 6);
        $display("test quiet config done");
        cfg_primary_i <= 8'hA0; do_reset();
        ticks(5); bus(0, `WWDT_OFS_COUNTER, 0, 4'hF); chk("off", rd, 32'd0);
        $display("test disabled config done");
        give_verdict();
    end
endmodule : testbench
`default_nettype wire
